// >>> design/dct_timers.sv
// Two counter/timers with their clock selection and register port
// Functional notes
// RL1 - Clock-select bits 7 and 2 read zero
// RL2 - Bit 6 picks reload high byte clock
// RL3 - Bit 5 picks reload timer low clock
// RL4 - Bit 4: timer one prescaler or sysclk
// RL5 - Bit 3: timer zero prescaler or sysclk
// RL6 - Prescale divides 12, 4, 48, ext/8
// RL7 - Count held as two separate bytes
// RL8 - Mode 0 uses thirteen bits, low five
// RL9 - Thirteen-bit wrap sets overflow flag
// RL10 - Counter select counts pin falling edges
// RL11 - Run bit and gate enable counting
// RL12 - Setting run keeps count value
// RL13 - Software loads count before run
// RL14 - Timer one mirrors timer zero
// RL15 - Mode 1 uses all sixteen bits
// RL16 - Mode 2 reloads low from high
// RL17 - Software presets low byte in mode 2
// RL18 - Timers configured independently
// RL19 - Interrupt request only when enabled
// RL20 - Counts pin events up to quarter rate
// RL21 - Overflow flag set, cleared, vector-cleared
// RL22 - Two-stage sync, one-cycle edge enable
module dct_timers (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       nrst,
    // Special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // Asynchronous pins
    input  wire logic       count_pin_zero,
    input  wire logic       count_pin_one,
    input  wire logic       gate_input_zero,
    input  wire logic       gate_input_one,
    input  wire logic       ext_clk_in,
    // Settings from neighbouring blocks
    input  wire logic       gate_zero_polarity,
    input  wire logic       gate_one_polarity,
    input  wire logic       timer_zero_irq_en,
    input  wire logic       timer_one_irq_en,
    input  wire logic       reload_timer_clk_source,
    input  wire logic       reload_timer_split,
    input  wire logic       isr_vector_zero,
    input  wire logic       isr_vector_one,
    // Requests and ticks
    output logic            timer_zero_irq,
    output logic            timer_one_irq,
    output logic            timer_zero_ovf_pulse,
    output logic            timer_one_ovf_pulse,
    output logic            reload_timer_low_tick,
    output logic            reload_timer_high_tick
);
    import dct_pkg::*;

    logic [7:0] tctrl_r;      // timer_control
    logic [7:0] tmode_r;      // timer_mode_reg
    logic [7:0] cksel_r;      // timer_clock_select
    logic [7:0] lo_r [2];     // Low count bytes
    logic [7:0] hi_r [2];     // High count bytes
    logic [4:0] s1_r;         // First sync stage
    logic [4:0] s2_r;         // Second sync stage
    logic [4:0] s3_r;         // Edge history
    logic [1:0] cnt_fall;     // Count pin falling edges
    logic       ext_rise;     // External clock rising edge
    logic [2:0] ext_cnt_r;    // External divide by eight
    logic       ext_tick;     // External clock / 8 enable
    logic [5:0] pre_cnt_r;    // Prescale counter
    logic [5:0] pre_lim;      // Prescale division
    logic       pre_tick;     // Prescaled clock enable
    logic [3:0] d12_cnt_r;    // Reload timer divide by twelve
    logic       d12_tick;     // Sysclk / 12 enable
    logic [1:0] tick;         // Per-timer count enable
    logic [1:0] ovf_set;      // Per-timer overflow event
    logic [1:0] vec_clr;      // Vector acknowledges
    logic [1:0] irq_en;       // Interrupt enables
    logic [1:0] gate_pol;     // Gate active levels
    logic [3:0] chk_gap_r;    // Cycles since a divide-by-twelve tick

    assign vec_clr  = {isr_vector_one, isr_vector_zero};
    assign irq_en   = {timer_one_irq_en, timer_zero_irq_en};
    assign gate_pol = {gate_one_polarity, gate_zero_polarity};

    // Two-stage synchronisers plus edge history
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1_r <= 5'h1F;
            s2_r <= 5'h1F;
            s3_r <= 5'h1F;
        end else begin
            s1_r <= {ext_clk_in, gate_input_one, gate_input_zero,
                     count_pin_one, count_pin_zero}; // RL22
            s2_r <= s1_r; // RL22
            s3_r <= s2_r;
        end
    end

    // One-cycle enables from synchronised edges
    assign cnt_fall = s3_r[1:0] & ~s2_r[1:0]; // RL10 RL22 RL20
    assign ext_rise = s2_r[4] & ~s3_r[4]; // RL22

    // External clock divided by eight
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ext_cnt_r <= 3'h0;
        end else if (ext_rise) begin
            ext_cnt_r <= ext_cnt_r + 3'h1;
        end
    end
    assign ext_tick = ext_rise && (ext_cnt_r == DCT_EXT_LAST); // RL6

    // Prescale division chosen by prescale_select
    always_comb begin
        unique case (dct_ps_t'(cksel_r[1:0]))
            DCT_PS_12: pre_lim = DCT_DIV_12;
            DCT_PS_4:  pre_lim = DCT_DIV_4;
            DCT_PS_48: pre_lim = DCT_DIV_48;
            DCT_PS_EXT: pre_lim = DCT_DIV_4;
        endcase
    end

    // Prescale counter, wraps at the chosen division
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pre_cnt_r <= 6'h00;
        end else if (pre_cnt_r >= pre_lim - 6'h01) begin
            pre_cnt_r <= 6'h00;
        end else begin
            pre_cnt_r <= pre_cnt_r + 6'h01;
        end
    end
    assign pre_tick = (cksel_r[1:0] == DCT_PS_EXT) ? ext_tick
                                                   : (pre_cnt_r >= pre_lim - 6'h01); // RL6

    // Check helper: gap since a divide-by-twelve tick, 4'hF while disarmed
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            chk_gap_r <= 4'hF;
        end else if (cksel_r[1:0] != 2'h0 || sfr_wr) begin
            chk_gap_r <= 4'hF;
        end else if (pre_tick) begin
            chk_gap_r <= 4'h0;
        end else if (chk_gap_r != 4'hF) begin
            chk_gap_r <= chk_gap_r + 4'h1;
        end
    end

    // Fixed divide by twelve for the reload timer
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            d12_cnt_r <= 4'h0;
        end else if (d12_cnt_r == DCT_D12_LAST) begin
            d12_cnt_r <= 4'h0;
        end else begin
            d12_cnt_r <= d12_cnt_r + 4'h1;
        end
    end
    assign d12_tick = (d12_cnt_r == DCT_D12_LAST);

    // Reload timer clock enables
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reload_timer_low_tick  <= 1'b0;
            reload_timer_high_tick <= 1'b0;
        end else begin
            // Low byte, or the whole timer when not split
            reload_timer_low_tick <= cksel_r[DCT_CK_RLD_LO] |
                (reload_timer_clk_source ? ext_tick : d12_tick); // RL3
            // High byte follows its own select only when split
            reload_timer_high_tick <= cksel_r[reload_timer_split ? DCT_CK_RLD_HI
                                                                 : DCT_CK_RLD_LO] |
                (reload_timer_clk_source ? ext_tick : d12_tick); // RL2
        end
    end

    // timer_clock_select, reserved bits held at zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cksel_r <= DCT_RST_BYTE;
        end else if (sfr_wr && sfr_addr == DCT_ADDR_CKSEL) begin
            cksel_r <= sfr_wdata & DCT_CKSEL_MASK; // RL1
        end
    end

    // timer_mode_reg
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tmode_r <= DCT_RST_BYTE;
        end else if (sfr_wr && sfr_addr == DCT_ADDR_TMODE) begin
            tmode_r <= sfr_wdata;
        end
    end

    // timer_control: overflow set beats software or vector clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tctrl_r <= DCT_RST_BYTE;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ovf_set[i]) begin
                    tctrl_r[DCT_TC_OVF0 + 2 * i] <= 1'b1; // RL21 RL9
                end else if (vec_clr[i]) begin
                    tctrl_r[DCT_TC_OVF0 + 2 * i] <= 1'b0; // RL21
                end else if (sfr_wr && sfr_addr == DCT_ADDR_TCTRL) begin
                    tctrl_r[DCT_TC_OVF0 + 2 * i] <= sfr_wdata[DCT_TC_OVF0 + 2 * i];
                end
            end
            // Run bits and external interrupt bits are plain storage
            if (sfr_wr && sfr_addr == DCT_ADDR_TCTRL) begin
                tctrl_r[6] <= sfr_wdata[6];
                tctrl_r[4] <= sfr_wdata[4];
                tctrl_r[3:0] <= sfr_wdata[3:0];
            end
        end
    end

    // One counter per timer, each from its own settings
    for (genvar i = 0; i < 2; i++) begin : g_tmr // RL14 RL18
        dct_mode_t  mode;     // Selected mode
        logic       gate_ok;  // Gate allows counting
        logic       src;      // Selected clock enable
        logic       wr_lo;    // Low byte write
        logic       wr_hi;    // High byte write
        logic [7:0] lo_nxt;   // Next low byte
        logic [7:0] hi_nxt;   // Next high byte
        logic       wrap;     // Count wraps this tick
        logic [12:0] c13;     // Thirteen-bit count

        assign mode    = dct_mode_t'(tmode_r[DCT_TM_NIB * i +: 2]);
        assign gate_ok = ~tmode_r[DCT_TM_NIB * i + DCT_TM_GATE] |
                         (s2_r[2 + i] == gate_pol[i]); // RL11
        // Pin edges replace the clock when counter select is set
        assign src = tmode_r[DCT_TM_NIB * i + DCT_TM_CTSEL] ? cnt_fall[i]
                   : (cksel_r[DCT_CK_T0 + i] | pre_tick); // RL10 RL4 RL5
        assign tick[i] = tctrl_r[DCT_TC_RUN0 + 2 * i] & gate_ok & src &
                         (mode != DCT_MSPLT); // RL11
        assign wr_lo = sfr_wr && sfr_addr == 8'(DCT_ADDR_T0LO + i);
        assign wr_hi = sfr_wr && sfr_addr == 8'(DCT_ADDR_T0HI + i);
        assign c13   = {hi_r[i], lo_r[i][4:0]} + 13'h0001;

        // Increment and wrap per mode
        always_comb begin
            lo_nxt = lo_r[i];
            hi_nxt = hi_r[i];
            wrap   = 1'b0;
            unique case (mode)
                DCT_M13: begin
                    // Upper three low bits left as they were
                    lo_nxt = {lo_r[i][7:5], c13[4:0]}; // RL8
                    hi_nxt = c13[12:5];
                    wrap   = (c13 == 13'h0000); // RL9
                end
                DCT_M16: begin
                    {hi_nxt, lo_nxt} = {hi_r[i], lo_r[i]} + 16'h0001; // RL15
                    wrap = ({hi_r[i], lo_r[i]} == 16'hFFFF); // RL15
                end
                DCT_M8R: begin
                    wrap   = (lo_r[i] == 8'hFF);
                    lo_nxt = wrap ? hi_r[i] : lo_r[i] + 8'h01; // RL16
                end
                DCT_MSPLT: begin
                    wrap = 1'b0;
                end
            endcase
        end
        assign ovf_set[i] = tick[i] & wrap;

        // Count bytes: software write wins over a count step
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                lo_r[i] <= DCT_RST_BYTE;
                hi_r[i] <= DCT_RST_BYTE;
            end else begin
                if (wr_lo) begin
                    lo_r[i] <= sfr_wdata; // RL7
                end else if (tick[i]) begin
                    lo_r[i] <= lo_nxt; // RL12
                end
                if (wr_hi) begin
                    hi_r[i] <= sfr_wdata; // RL7
                end else if (tick[i]) begin
                    hi_r[i] <= hi_nxt;
                end
            end
        end
    end

    // Overflow pulses and gated interrupt requests
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            timer_zero_ovf_pulse <= 1'b0;
            timer_one_ovf_pulse  <= 1'b0;
            timer_zero_irq       <= 1'b0;
            timer_one_irq        <= 1'b0;
        end else begin
            timer_zero_ovf_pulse <= ovf_set[0];
            timer_one_ovf_pulse  <= ovf_set[1];
            timer_zero_irq <= tctrl_r[DCT_TC_OVF0] & irq_en[0]; // RL19
            timer_one_irq  <= tctrl_r[DCT_TC_OVF0 + 2] & irq_en[1]; // RL19
        end
    end

    // Read data, registered one cycle after the read strobe
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= DCT_RST_BYTE;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                DCT_ADDR_TCTRL: sfr_rdata <= tctrl_r;
                DCT_ADDR_TMODE: sfr_rdata <= tmode_r;
                DCT_ADDR_T0LO:  sfr_rdata <= lo_r[0];
                DCT_ADDR_T1LO:  sfr_rdata <= lo_r[1];
                DCT_ADDR_T0HI:  sfr_rdata <= hi_r[0];
                DCT_ADDR_T1HI:  sfr_rdata <= hi_r[1];
                DCT_ADDR_CKSEL: sfr_rdata <= cksel_r & DCT_CKSEL_MASK; // RL1
                default:        sfr_rdata <= DCT_RST_BYTE;
            endcase
        end
    end

    // Checks on the register, counting and interrupt behaviour
    a_cksel_reserved: assert property (@(posedge clock) disable iff (!nrst) // RL1
        (sfr_wr && sfr_addr == DCT_ADDR_CKSEL) |=> (cksel_r[7] == 1'b0 && cksel_r[2] == 1'b0 &&
        cksel_r[6:3] == $past(sfr_wdata[6:3])))
        else $error("clock select reserved bits not zero");
    a_prescale_twelve: assert property (@(posedge clock) disable iff (!nrst) // RL6
        (chk_gap_r != 4'hF) |-> (pre_tick == (chk_gap_r == DCT_D12_LAST)))
        else $error("prescale by twelve period wrong");
    a_edge_single: assert property (@(posedge clock) disable iff (!nrst) // RL22
        (cnt_fall != 2'b00) |=> (cnt_fall == 2'b00))
        else $error("count edge enable longer than one cycle");
    a_mode2_reload: assert property (@(posedge clock) disable iff (!nrst) // RL16
        (tick[0] && tmode_r[1:0] == 2'b10 && lo_r[0] == 8'hFF && !sfr_wr)
        |=> (lo_r[0] == hi_r[0] && lo_r[0] == $past(hi_r[0]) && tctrl_r[5]))
        else $error("mode two reload or flag wrong");
    a_mode0_wrap: assert property (@(posedge clock) disable iff (!nrst) // RL9
        (tick[1] && tmode_r[5:4] == 2'b00 && hi_r[1] == 8'hFF && lo_r[1][4:0] == 5'h1F
        && !sfr_wr) |=> (hi_r[1] == 8'h00 && lo_r[1][4:0] == 5'h00 && tctrl_r[7]))
        else $error("thirteen bit wrap wrong");
    a_run_hold: assert property (@(posedge clock) disable iff (!nrst) // RL11
        (!tctrl_r[4] && !sfr_wr) |=> ($stable(lo_r[0]) && $stable(hi_r[0])))
        else $error("timer zero moved while stopped");
    a_sysclk_step: assert property (@(posedge clock) disable iff (!nrst) // RL5
        (tctrl_r[4] && tmode_r[3:0] == 4'h1 && cksel_r[3] && !sfr_wr)
        |=> ({hi_r[0], lo_r[0]} == $past({hi_r[0], lo_r[0]}) + 16'h0001))
        else $error("timer zero not stepping on system clock");
    a_irq_gate: assert property (@(posedge clock) disable iff (!nrst) // RL19
        timer_one_irq |-> $past(irq_en[1] && tctrl_r[7]))
        else $error("timer one request without enable and flag");
    a_flag_set_wins: assert property (@(posedge clock) disable iff (!nrst) // RL21
        (ovf_set[0] && vec_clr[0]) |=> tctrl_r[5])
        else $error("overflow lost against clear");
endmodule

// >>> design/dct_pkg.sv
// Constants and types shared by the dual counter/timer block
package dct_pkg;
    // Register addresses on the special function register port
    localparam logic [7:0] DCT_ADDR_TCTRL = 8'h88; // timer_control
    localparam logic [7:0] DCT_ADDR_TMODE = 8'h89; // timer_mode_reg
    localparam logic [7:0] DCT_ADDR_T0LO  = 8'h8A; // timer_zero_low_byte
    localparam logic [7:0] DCT_ADDR_T1LO  = 8'h8B; // timer_one_low_byte
    localparam logic [7:0] DCT_ADDR_T0HI  = 8'h8C; // timer_zero_high_byte
    localparam logic [7:0] DCT_ADDR_T1HI  = 8'h8D; // timer_one_high_byte
    localparam logic [7:0] DCT_ADDR_CKSEL = 8'h8E; // timer_clock_select
    // Values after reset
    localparam logic [7:0] DCT_RST_BYTE   = 8'h00;
    // Writable and readable bits of timer_clock_select
    localparam logic [7:0] DCT_CKSEL_MASK = 8'h7B;
    // Field positions in timer_clock_select
    localparam int DCT_CK_RLD_HI  = 6; // reload_timer_high_clk_sel
    localparam int DCT_CK_RLD_LO  = 5; // reload_timer_low_clk_sel
    localparam int DCT_CK_T0      = 3; // timer_zero_clk_sel, timer one at +1
    // Field positions in timer_control (timer one at +2)
    localparam int DCT_TC_RUN0    = 4;
    localparam int DCT_TC_OVF0    = 5;
    // Field positions in each timer nibble of timer_mode_reg
    localparam int DCT_TM_NIB     = 4;
    localparam int DCT_TM_CTSEL   = 2;
    localparam int DCT_TM_GATE    = 3;
    // Prescale division counts in system clock cycles
    localparam logic [5:0] DCT_DIV_12 = 6'h0C;
    localparam logic [5:0] DCT_DIV_4  = 6'h04;
    localparam logic [5:0] DCT_DIV_48 = 6'h30;
    // Last count of the external clock divide by eight
    localparam logic [2:0] DCT_EXT_LAST = 3'h7;
    // Last count of the fixed divide by twelve for the reload timer
    localparam logic [3:0] DCT_D12_LAST = 4'hB;
    // Prescale select codes
    typedef enum logic [1:0] {
        DCT_PS_12  = 2'b00,
        DCT_PS_4   = 2'b01,
        DCT_PS_48  = 2'b10,
        DCT_PS_EXT = 2'b11
    } dct_ps_t;
    // Timer modes
    typedef enum logic [1:0] {
        DCT_M13   = 2'b00,
        DCT_M16   = 2'b01,
        DCT_M8R   = 2'b10,
        DCT_MSPLT = 2'b11
    } dct_mode_t;
endpackage

// >>> sim/dct_pin_model.sv
// Far-side model: external count pins and free-running external oscillator
module dct_pin_model (
    // Clock
    input  wire logic clock,
    // Pins towards the timers
    output logic      count_pin_zero,
    output logic      count_pin_one,
    output logic      ext_clk_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] pin_r = 2'b11; // Count pins, idle high

    assign count_pin_zero = pin_r[0];
    assign count_pin_one  = pin_r[1];

    // Oscillator of six system cycles, phase unrelated to the clock
    initial begin
        ext_clk_in = 1'b0;
        #37;
        forever begin
            #300 ext_clk_in = ~ext_clk_in;
        end
    end

    // Falling edges on one pin, each level held three cycles
    task automatic pulse_count(input int which, input int n);
        for (int i = 0; i < n; i++) begin
            repeat (3) @(posedge clock);
            pin_r[which] <= 1'b0;
            repeat (3) @(posedge clock);
            pin_r[which] <= 1'b1;
        end
    endtask
endmodule

// >>> sim/tb_dct_timers.sv
// Self-checking bench for the dual counter/timer block
module tb_dct_timers;
    import dct_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // Design inputs
    logic       clock     = 1'b0;
    logic       nrst      = 1'b0;
    logic [7:0] sfr_addr  = 8'h00;
    logic       sfr_wr    = 1'b0;
    logic       sfr_rd    = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [1:0] gate_in   = 2'b00; // Gate pins, timer one in bit 1
    logic [1:0] gate_pol  = 2'b11; // High-active gates
    logic [1:0] irq_en    = 2'b01; // Timer zero enabled only
    logic       rld_split = 1'b0;
    logic [1:0] vec       = 2'b00; // Vector acknowledges
    // Design outputs and pins
    logic [7:0] sfr_rdata;
    logic [1:0] irq;
    logic [1:0] ovf;
    logic       rld_lo;
    logic       rld_hi;
    logic       cp0;
    logic       cp1;
    logic       ext_clk;
    // Bookkeeping
    int         err_count   = 0;
    int         checks_done = 0;
    int         cycles      = 0;
    int         ovf1_seen   = 0;

    // 100 ns system clock
    always #50 clock = ~clock;

    dct_pin_model pins (.clock(clock), .count_pin_zero(cp0), .count_pin_one(cp1),
                        .ext_clk_in(ext_clk));

    dct_timers uut (
        .clock(clock), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .count_pin_zero(cp0), .count_pin_one(cp1), .gate_input_zero(gate_in[0]),
        .gate_input_one(gate_in[1]), .ext_clk_in(ext_clk),
        .gate_zero_polarity(gate_pol[0]), .gate_one_polarity(gate_pol[1]),
        .timer_zero_irq_en(irq_en[0]), .timer_one_irq_en(irq_en[1]),
        .reload_timer_clk_source(1'b0), .reload_timer_split(rld_split),
        .isr_vector_zero(vec[0]), .isr_vector_one(vec[1]),
        .timer_zero_irq(irq[0]), .timer_one_irq(irq[1]),
        .timer_zero_ovf_pulse(ovf[0]), .timer_one_ovf_pulse(ovf[1]),
        .reload_timer_low_tick(rld_lo), .reload_timer_high_tick(rld_hi));

    // Cycle ceiling and timer one overflow tally
    always @(posedge clock) begin
        cycles++;
        if (ovf[1] === 1'b1) begin
            ovf1_seen++;
        end
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("errors=%0d checks=%0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_wr    <= 1'b1;
        sfr_addr  <= a;
        sfr_wdata <= d;
        @(posedge clock);
        sfr_wr <= 1'b0;
    endtask

    // One-cycle read strobe, data registered at the taking edge
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        sfr_rd   <= 1'b1;
        sfr_addr <= a;
        @(posedge clock);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask

    // Edges until the next overflow pulse of one timer, bounded
    task automatic wait_ovf(input int which, output int n);
        n = 0;
        do begin
            @(posedge clock);
            #1 n++;
        end while (ovf[which] !== 1'b1 && n < 500);
    endtask

    // Reload timer ticks over 24 cycles
    task automatic count_ticks(output int lo, output int hi);
        lo = 0;
        hi = 0;
        repeat (3) @(posedge clock);
        repeat (24) begin
            @(posedge clock);
            #1 lo += int'(rld_lo);
            hi += int'(rld_hi);
        end
    endtask

    // Clock-select storage, reserved bits and an unmapped address
    task automatic s_regs();
        logic [7:0] d;
        reg_rd(DCT_ADDR_CKSEL, d);
        check(16'(d), 16'h0000);
        reg_wr(DCT_ADDR_CKSEL, 8'hFF);
        reg_rd(DCT_ADDR_CKSEL, d);
        check(16'(d), 16'h007B);
        reg_wr(8'h8F, 8'hA5);
        reg_rd(8'h8F, d);
        check(16'(d), 16'h0000);
    endtask

    // Reload timer byte clocks: system clock or divided by twelve
    task automatic s_reload_clk();
        int lo;
        int hi;
        rld_split <= 1'b1;
        reg_wr(DCT_ADDR_CKSEL, 8'h20);
        count_ticks(lo, hi);
        check(16'(lo), 16'd24);
        check(16'(hi), 16'd2);
        reg_wr(DCT_ADDR_CKSEL, 8'h40);
        count_ticks(lo, hi);
        check(16'(lo), 16'd2);
        check(16'(hi), 16'd24);
        rld_split <= 1'b0;
    endtask

    // Sixteen-bit wrap on system clock, flag, request and vector clear
    task automatic s_mode1();
        logic [7:0] d;
        int         n;
        reg_wr(DCT_ADDR_T0LO, 8'hFD);
        reg_wr(DCT_ADDR_T0HI, 8'hFF);
        reg_wr(DCT_ADDR_CKSEL, 8'h08);
        reg_wr(DCT_ADDR_TMODE, 8'h01);
        reg_wr(DCT_ADDR_TCTRL, 8'h10);
        wait_ovf(0, n);
        check(16'(n), 16'd3);
        @(posedge clock);
        #1 check(16'(irq[0]), 16'h0001);
        reg_rd(DCT_ADDR_TCTRL, d);
        check(16'(d & 8'h30), 16'h0030);
        vec[0] <= 1'b1;
        @(posedge clock);
        vec[0] <= 1'b0;
        repeat (2) @(posedge clock);
        #1 check(16'(irq[0]), 16'h0000);
        reg_wr(DCT_ADDR_TCTRL, 8'h00);
    endtask

    // Thirteen-bit wrap on timer one, request masked
    task automatic s_mode0();
        int n;
        reg_wr(DCT_ADDR_T1LO, 8'hFE);
        reg_wr(DCT_ADDR_T1HI, 8'hFF);
        reg_wr(DCT_ADDR_CKSEL, 8'h10);
        reg_wr(DCT_ADDR_TMODE, 8'h00);
        reg_wr(DCT_ADDR_TCTRL, 8'h40);
        wait_ovf(1, n);
        check(16'(n), 16'd2);
        @(posedge clock);
        #1 check(16'(irq[1]), 16'h0000);
        reg_wr(DCT_ADDR_TCTRL, 8'h00);
    endtask

    // Eight-bit reload period, then every prescale code
    task automatic s_mode2();
        logic [7:0] d;
        int         n;
        int         per[4] = '{24, 8, 96, 96};
        reg_wr(DCT_ADDR_T0LO, 8'hFE);
        reg_wr(DCT_ADDR_T0HI, 8'hF0);
        reg_wr(DCT_ADDR_CKSEL, 8'h08);
        reg_wr(DCT_ADDR_TMODE, 8'h02);
        reg_wr(DCT_ADDR_TCTRL, 8'h10);
        wait_ovf(0, n);
        wait_ovf(0, n);
        check(16'(n), 16'd16);
        reg_rd(DCT_ADDR_T0HI, d);
        check(16'(d), 16'h00F0);
        reg_wr(DCT_ADDR_T0HI, 8'hFE);
        for (int c = 0; c < 4; c++) begin
            reg_wr(DCT_ADDR_CKSEL, 8'(c));
            wait_ovf(0, n);
            wait_ovf(0, n);
            check(16'(n), 16'(per[c]));
        end
        // Overflow in the second of the two cycles the vector acknowledge is high
        reg_wr(DCT_ADDR_CKSEL, 8'h08);
        reg_wr(DCT_ADDR_T0HI, 8'hFF);
        vec[0] <= 1'b1;
        repeat (2) @(posedge clock);
        vec[0] <= 1'b0;
        reg_rd(DCT_ADDR_TCTRL, d);
        check(16'(d & 8'h20), 16'h0020);
        reg_wr(DCT_ADDR_TCTRL, 8'h00);
    endtask

    // Pin-event counting on timer one, held off by its gate
    task automatic s_counter();
        int base;
        reg_wr(DCT_ADDR_T1LO, 8'hFD);
        reg_wr(DCT_ADDR_T1HI, 8'hFD);
        reg_wr(DCT_ADDR_TMODE, 8'hE0);
        reg_wr(DCT_ADDR_TCTRL, 8'h40);
        base = ovf1_seen;
        pins.pulse_count(1, 3);
        repeat (6) @(posedge clock);
        check(16'(ovf1_seen - base), 16'd0);
        gate_in[1] <= 1'b1;
        pins.pulse_count(1, 3);
        repeat (6) @(posedge clock);
        check(16'(ovf1_seen - base), 16'd1);
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        s_regs();
        s_reload_clk();
        s_mode1();
        s_mode0();
        s_mode2();
        s_counter();
        give_verdict();
    end
endmodule
